// ===== core/uaer_pkg.sv
// constants, field layouts and carrier types for the audio endpoint router
// assumes a single 25 MHz core clock and a USB engine that decodes tokens
package uaer_pkg;

    // timing, as printed, and the derived cycle counts
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned POR_TIME_NS = 700_000;
    localparam int unsigned POR_CYCLES = POR_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned HID_PERIOD_NS = 32_000_000;
    localparam int unsigned HID_CYCLES = HID_PERIOD_NS / CLK_PERIOD_NS;

    // endpoint numbers
    localparam logic [3:0] EP_CTRL = 4'h0;
    localparam logic [3:0] EP_PLAY = 4'h2;
    localparam logic [3:0] EP_REC = 4'h4;
    localparam logic [3:0] EP_HID = 4'h5;

    // control request kinds served on the default endpoint
    localparam logic [1:0] REQ_STANDARD = 2'h0;
    localparam logic [1:0] REQ_CLASS = 2'h1;

    // sample widths
    localparam int unsigned SAMPLE_W = 16;
    localparam int unsigned BYTE_W = 8;

    // human-interface pins, active high
    localparam int unsigned HID_PIN_COUNT = 3;
    localparam int unsigned HID_MUTE_POS = 0;
    localparam int unsigned HID_VOLUP_POS = 1;
    localparam int unsigned HID_VOLDN_POS = 2;

    // record packet byte counts
    localparam logic [2:0] REC_BYTES_ST16 = 3'h4;
    localparam logic [2:0] REC_BYTES_HALF = 3'h2;
    localparam logic [2:0] REC_BYTES_MO8 = 3'h1;

    // outgoing channel status layout
    localparam int unsigned CS_W = 32;
    localparam int unsigned CS_PRO_POS = 0;
    localparam logic CS_CONSUMER = 1'b0;
    localparam int unsigned CS_AUDIO_POS = 1;
    localparam logic CS_PCM = 1'b0;
    localparam int unsigned CS_COPY_POS = 2;
    localparam logic CS_COPYRIGHT = 1'b0;
    localparam int unsigned CS_CAT_POS = 8;
    localparam int unsigned CS_CAT_W = 8;
    localparam logic [7:0] CS_CAT_DD_CONV = 8'h02;
    localparam int unsigned CS_GEN_POS = 15;
    localparam logic CS_GEN_ORIGINAL = 1'b0;
    localparam int unsigned CS_FS_POS = 24;
    localparam int unsigned CS_FS_W = 4;
    localparam logic [3:0] CS_FS_48K = 4'h2;
    localparam logic [3:0] CS_FS_44K1 = 4'h0;
    localparam logic [3:0] CS_FS_32K = 4'h3;

    typedef enum logic [1:0] {RATE_48K, RATE_44K1, RATE_32K, RATE_OTHER} uaer_rate_t;

    typedef struct packed {
        logic active;
        logic mono;
        logic bits8;
        uaer_rate_t rate;
    } uaer_fmt_t;

    typedef struct packed {
        logic valid;
        logic dir_in;
        logic [3:0] ep;
    } uaer_token_t;

    typedef struct packed {
        logic valid;
        logic [1:0] rtype;
    } uaer_ctrl_req_t;

    typedef struct packed {
        logic [SAMPLE_W-1:0] left;
        logic [SAMPLE_W-1:0] right;
    } uaer_stereo_t;

    typedef struct packed {
        logic copy_free;
        logic original;
    } uaer_copy_mgmt_t;

endpackage

// ===== core/uaer_pb_conv.sv
// playback format converter: host words to 16-bit stereo pairs
// assumes words arrive left first for stereo formats, one per valid cycle
`timescale 1ns/10ps
module uaer_pb_conv
    import uaer_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire uaer_fmt_t fmt_in,
    input wire logic word_valid_in,
    input wire logic [SAMPLE_W-1:0] word_in,
    output logic pair_valid_out,
    output uaer_stereo_t pair_out
);

    typedef struct packed {
        logic have_left;
        logic [SAMPLE_W-1:0] left;
        logic pair_valid;
        uaer_stereo_t pair;
    } uaer_conv_st_t;

    uaer_conv_st_t st_q;
    uaer_conv_st_t st_d;
    logic [SAMPLE_W-1:0] wide;

    always_comb begin
        st_d = st_q;
        st_d.pair_valid = 1'b0;
        wide = fmt_in.bits8 ? {word_in[BYTE_W-1:0], {BYTE_W{1'b0}}} : word_in;
        if (!fmt_in.active) begin
            st_d.have_left = 1'b0;
        end else if (word_valid_in) begin
            if (fmt_in.mono) begin
                st_d.pair = '{left: wide, right: wide};
                st_d.pair_valid = 1'b1;
            end else if (!st_q.have_left) begin
                st_d.left = wide;
                st_d.have_left = 1'b1;
            end else begin
                st_d.pair = '{left: st_q.left, right: wide};
                st_d.pair_valid = 1'b1;
                st_d.have_left = 1'b0;
            end
        end
        if (rst_in) begin
            st_d = '0;
        end
    end

    always_ff @(posedge clk_in) begin
        st_q <= st_d;
    end

    assign pair_valid_out = st_q.pair_valid;
    assign pair_out = st_q.pair;

endmodule // uaer_pb_conv

// ===== core/uaer_core.sv
// endpoint router core: routes playback, record and hid reports
// assumes a usb engine that hands over decoded tokens and requests on MCLK_IN
`timescale 1ns/10ps
module uaer_core
    import uaer_pkg::*;
#(
    parameter int unsigned POR_CYCLES_P = POR_CYCLES,
    parameter int unsigned HID_CYCLES_P = HID_CYCLES,
    parameter int unsigned RATE_W = 8
)(
    input wire logic MCLK_IN,
    input wire logic RESET_IN,
    input wire logic MUTE_REQUEST_PIN_IN,
    input wire logic VOLUME_UP_PIN_IN,
    input wire logic VOLUME_DOWN_PIN_IN,
    input wire uaer_token_t TOKEN_IN,
    output logic TOKEN_ACK_OUT,
    output logic TOKEN_STALL_OUT,
    input wire uaer_ctrl_req_t CTRL_REQ_IN,
    output logic CTRL_ACK_OUT,
    output logic CTRL_STALL_OUT,
    input wire uaer_fmt_t PB_FMT_IN,
    input wire logic PB_WORD_VALID_IN,
    input wire logic [SAMPLE_W-1:0] PB_WORD_IN,
    input wire logic SOF_IN,
    output logic [RATE_W-1:0] PB_RATE_OUT,
    output logic DAC_VALID_OUT,
    output uaer_stereo_t DAC_SAMPLE_OUT,
    output logic SPDIF_TX_VALID_OUT,
    output uaer_stereo_t SPDIF_TX_SAMPLE_OUT,
    output logic [CS_W-1:0] SPDIF_TX_STATUS_OUT,
    input wire uaer_fmt_t REC_FMT_IN,
    input wire logic REC_TICK_IN,
    input wire uaer_stereo_t ADC_SAMPLE_IN,
    input wire uaer_stereo_t SPDIF_RX_SAMPLE_IN,
    input wire logic SPDIF_RX_LOCK_IN,
    input wire uaer_rate_t SPDIF_RX_RATE_IN,
    input wire uaer_copy_mgmt_t SPDIF_RX_COPY_MGMT_IN,
    output logic REC_VALID_OUT,
    output logic [2*SAMPLE_W-1:0] REC_DATA_OUT,
    output logic [2:0] REC_BYTES_OUT,
    output logic REC_FROM_SPDIF_OUT,
    output logic [HID_PIN_COUNT-1:0] HID_REPORT_OUT,
    output logic HID_PEND_OUT,
    output logic LOGIC_RESET_OUT
);

    localparam int unsigned POR_W = $clog2(POR_CYCLES_P + 1);
    localparam int unsigned HID_W = $clog2(HID_CYCLES_P + 1);

    typedef struct packed {
        logic [POR_W-1:0] por_cnt;
        logic [HID_PIN_COUNT-1:0] s1;
        logic [HID_PIN_COUNT-1:0] s2;
        logic [HID_PIN_COUNT-1:0] s3;
        logic [HID_PIN_COUNT-1:0] level;
        logic [HID_W-1:0] hid_cnt;
        logic hid_pend;
        logic [HID_PIN_COUNT-1:0] report;
        logic tok_ack;
        logic tok_stall;
        logic ctrl_ack;
        logic ctrl_stall;
        logic [RATE_W-1:0] pair_cnt;
        logic [RATE_W-1:0] pb_rate;
        logic [CS_W-1:0] status;
        logic rec_valid;
        logic [2*SAMPLE_W-1:0] rec_data;
        logic [2:0] rec_bytes;
        logic rec_spdif;
    } uaer_core_st_t;

    uaer_core_st_t st_q;
    uaer_core_st_t st_d;
    logic held;
    logic pair_valid;
    uaer_stereo_t pair;
    logic [HID_PIN_COUNT-1:0] pins;
    logic [HID_PIN_COUNT-1:0] agree;
    logic use_spdif;
    logic ep_ok;
    uaer_stereo_t src;

    assign held = (st_q.por_cnt != '0);

    always_comb begin
        pins = '0;
        pins[HID_MUTE_POS] = MUTE_REQUEST_PIN_IN;
        pins[HID_VOLUP_POS] = VOLUME_UP_PIN_IN;
        pins[HID_VOLDN_POS] = VOLUME_DOWN_PIN_IN;
    end

    // format conversion ahead of both outputs
    uaer_pb_conv u_pb_conv (
        .clk_in(MCLK_IN),
        .rst_in(RESET_IN | held),
        .fmt_in(PB_FMT_IN),
        .word_valid_in(PB_WORD_VALID_IN),
        .word_in(PB_WORD_IN),
        .pair_valid_out(pair_valid),
        .pair_out(pair)
    );

    // s/pdif only when locked and usable
    // rate match relied upon, checked defensively
    // copied material falls back to adc
    assign use_spdif = SPDIF_RX_LOCK_IN
                       && (SPDIF_RX_RATE_IN != RATE_OTHER)
                       && (SPDIF_RX_RATE_IN == REC_FMT_IN.rate)
                       && SPDIF_RX_COPY_MGMT_IN.original;
    assign src = use_spdif ? SPDIF_RX_SAMPLE_IN : ADC_SAMPLE_IN;

    always_comb begin
        if (TOKEN_IN.dir_in) begin
            ep_ok = (TOKEN_IN.ep == EP_CTRL) || (TOKEN_IN.ep == EP_REC)
                    || (TOKEN_IN.ep == EP_HID);
        end else begin
            ep_ok = (TOKEN_IN.ep == EP_CTRL) || (TOKEN_IN.ep == EP_PLAY);
        end
    end

    always_comb begin
        st_d = st_q;
        st_d.tok_ack = 1'b0;
        st_d.tok_stall = 1'b0;
        st_d.ctrl_ack = 1'b0;
        st_d.ctrl_stall = 1'b0;
        // three-stage pin synchroniser; level moves once stages 2 and 3 agree
        st_d.s1 = pins;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        agree = ~(st_q.s2 ^ st_q.s3);
        st_d.level = (agree & st_q.s3) | (~agree & st_q.level);
        if (held) begin
            st_d.por_cnt = st_q.por_cnt - POR_W'(1);
        end

        if (TOKEN_IN.valid) begin
            st_d.tok_ack = ep_ok;
            st_d.tok_stall = !ep_ok;
            if (ep_ok && TOKEN_IN.dir_in && (TOKEN_IN.ep == EP_HID)) begin
                st_d.hid_pend = 1'b0;
            end
            // record word consumed by its in token
            if (ep_ok && TOKEN_IN.dir_in && (TOKEN_IN.ep == EP_REC)) begin
                st_d.rec_valid = 1'b0;
            end
        end

        if (CTRL_REQ_IN.valid) begin
            st_d.ctrl_ack = (CTRL_REQ_IN.rtype == REQ_STANDARD)
                            || (CTRL_REQ_IN.rtype == REQ_CLASS);
            st_d.ctrl_stall = !st_d.ctrl_ack;
        end

        // periodic report, set wins over the in-token clear
        // report path touches no audio state
        if (st_q.hid_cnt == '0) begin
            st_d.hid_cnt = HID_W'(HID_CYCLES_P - 1);
            st_d.report = st_q.level;
            st_d.hid_pend = 1'b1;
        end else begin
            st_d.hid_cnt = st_q.hid_cnt - HID_W'(1);
        end

        // adaptive, pairs per frame follow host delivery
        if (SOF_IN) begin
            st_d.pb_rate = st_q.pair_cnt;
            st_d.pair_cnt = RATE_W'(pair_valid);
        end else if (pair_valid) begin
            st_d.pair_cnt = st_q.pair_cnt + RATE_W'(1);
        end

        // fixed status, rate field from host stream
        st_d.status = '0;
        st_d.status[CS_PRO_POS] = CS_CONSUMER;
        st_d.status[CS_AUDIO_POS] = CS_PCM;
        st_d.status[CS_COPY_POS] = CS_COPYRIGHT;
        st_d.status[CS_CAT_POS +: CS_CAT_W] = CS_CAT_DD_CONV;
        st_d.status[CS_GEN_POS] = CS_GEN_ORIGINAL;
        unique case (PB_FMT_IN.rate)
            RATE_48K: st_d.status[CS_FS_POS +: CS_FS_W] = CS_FS_48K;
            RATE_44K1: st_d.status[CS_FS_POS +: CS_FS_W] = CS_FS_44K1;
            RATE_32K: st_d.status[CS_FS_POS +: CS_FS_W] = CS_FS_32K;
            RATE_OTHER: st_d.status[CS_FS_POS +: CS_FS_W] = '0;
        endcase

        // capture paced by the device's own sample tick
        if (REC_TICK_IN && REC_FMT_IN.active) begin
            st_d.rec_valid = 1'b1;
            st_d.rec_spdif = use_spdif;
            // mono, 8-bit or both reductions; both together keep one byte, the top of the left channel
            unique case ({REC_FMT_IN.mono, REC_FMT_IN.bits8})
                2'h0: begin
                    st_d.rec_data = {src.left, src.right};
                    st_d.rec_bytes = REC_BYTES_ST16;
                end
                2'h1: begin
                    st_d.rec_data = {{SAMPLE_W{1'b0}}, src.left[SAMPLE_W-1 -: BYTE_W],
                                     src.right[SAMPLE_W-1 -: BYTE_W]};
                    st_d.rec_bytes = REC_BYTES_HALF;
                end
                2'h2: begin
                    st_d.rec_data = {{SAMPLE_W{1'b0}}, src.left};
                    st_d.rec_bytes = REC_BYTES_HALF;
                end
                2'h3: begin
                    st_d.rec_data = {{(2*SAMPLE_W-BYTE_W){1'b0}},
                                     src.left[SAMPLE_W-1 -: BYTE_W]};
                    st_d.rec_bytes = REC_BYTES_MO8;
                end
            endcase
        end

        if (held) begin
            st_d.hid_cnt = HID_W'(HID_CYCLES_P - 1);
            st_d.hid_pend = 1'b0;
            st_d.rec_valid = 1'b0;
            st_d.tok_ack = 1'b0;
            st_d.tok_stall = 1'b0;
            st_d.ctrl_ack = 1'b0;
            st_d.ctrl_stall = 1'b0;
            st_d.pair_cnt = '0;
        end
        if (RESET_IN) begin
            st_d = '0;
            st_d.por_cnt = POR_W'(POR_CYCLES_P);
        end
    end

    // single reference clock for every path
    always_ff @(posedge MCLK_IN) begin
        st_q <= st_d;
    end

    assign TOKEN_ACK_OUT = st_q.tok_ack;
    assign TOKEN_STALL_OUT = st_q.tok_stall;
    assign CTRL_ACK_OUT = st_q.ctrl_ack;
    assign CTRL_STALL_OUT = st_q.ctrl_stall;
    assign PB_RATE_OUT = st_q.pb_rate;
    assign DAC_VALID_OUT = pair_valid;
    assign DAC_SAMPLE_OUT = pair;
    // encoder fed only at a supported rate
    assign SPDIF_TX_VALID_OUT = pair_valid && (PB_FMT_IN.rate != RATE_OTHER);
    assign SPDIF_TX_SAMPLE_OUT = pair;
    assign SPDIF_TX_STATUS_OUT = st_q.status;
    assign REC_VALID_OUT = st_q.rec_valid;
    assign REC_DATA_OUT = st_q.rec_data;
    assign REC_BYTES_OUT = st_q.rec_bytes;
    assign REC_FROM_SPDIF_OUT = st_q.rec_spdif;
    assign HID_REPORT_OUT = st_q.report;
    assign HID_PEND_OUT = st_q.hid_pend;
    assign LOGIC_RESET_OUT = held;

endmodule // uaer_core

// ===== tb/uaer_core_properties.sv
// port assertions for the endpoint router core
// bound to uaer_core, one clock, synchronous reset active high
`timescale 1ns/10ps
module uaer_core_properties
    import uaer_pkg::*;
(
    input wire logic MCLK_IN,
    input wire logic RESET_IN,
    input wire uaer_token_t TOKEN_IN,
    input wire logic TOKEN_ACK_OUT,
    input wire logic TOKEN_STALL_OUT,
    input wire uaer_ctrl_req_t CTRL_REQ_IN,
    input wire logic CTRL_ACK_OUT,
    input wire logic CTRL_STALL_OUT,
    input wire uaer_fmt_t PB_FMT_IN,
    input wire logic DAC_VALID_OUT,
    input wire logic SPDIF_TX_VALID_OUT,
    input wire logic [CS_W-1:0] SPDIF_TX_STATUS_OUT,
    input wire logic REC_TICK_IN,
    input wire logic REC_VALID_OUT,
    input wire logic LOGIC_RESET_OUT
);
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (RESET_IN);
    logic ep_ok;
    logic [3:0] fs;
    assign ep_ok = TOKEN_IN.dir_in ? (TOKEN_IN.ep inside {4'h0, 4'h4, 4'h5})
        : (TOKEN_IN.ep inside {4'h0, 4'h2});
    assign fs = PB_FMT_IN.rate == RATE_48K ? 4'h2 : PB_FMT_IN.rate == RATE_32K ? 4'h3 : 4'h0;
    property p_ack; TOKEN_IN.valid && ep_ok |=> TOKEN_ACK_OUT && !TOKEN_STALL_OUT; endproperty
    a_ack: assert property (p_ack) else $error("token not acked");
    property p_stall; TOKEN_IN.valid && !ep_ok |=> TOKEN_STALL_OUT && !TOKEN_ACK_OUT; endproperty
    a_stall: assert property (p_stall) else $error("token not stalled");
    property p_ctrl; CTRL_REQ_IN.valid |=> CTRL_ACK_OUT != CTRL_STALL_OUT
        && CTRL_STALL_OUT == $past(CTRL_REQ_IN.rtype[1]); endproperty
    a_ctrl: assert property (p_ctrl) else $error("bad request answer");
    property p_tx; SPDIF_TX_VALID_OUT == (DAC_VALID_OUT && PB_FMT_IN.rate != RATE_OTHER); endproperty
    a_tx: assert property (p_tx) else $error("encoder valid wrong");
    property p_csfix; !$past(RESET_IN) |-> (SPDIF_TX_STATUS_OUT & 32'hF0FF_FFFF) == 32'h0000_0200;
    endproperty
    a_csfix: assert property (p_csfix) else $error("status fixed bits");
    property p_csfs; !$past(RESET_IN) |-> SPDIF_TX_STATUS_OUT[27:24] == $past(fs); endproperty
    a_csfs: assert property (p_csfs) else $error("status rate field");
    property p_rclr; TOKEN_IN.valid && TOKEN_IN.dir_in && TOKEN_IN.ep == 4'h4 && !REC_TICK_IN
        |=> !REC_VALID_OUT; endproperty
    a_rclr: assert property (p_rclr) else $error("record word kept");
    property p_hold; disable iff (1'b0) RESET_IN |=> (LOGIC_RESET_OUT && !REC_VALID_OUT)
        ##1 LOGIC_RESET_OUT [*7]; endproperty
    a_hold: assert property (p_hold) else $error("hold released early");
    cover property (DAC_VALID_OUT && !SPDIF_TX_VALID_OUT);
    cover property (REC_VALID_OUT ##1 !REC_VALID_OUT);
    cover property ($fell(LOGIC_RESET_OUT));
endmodule // uaer_core_properties

bind uaer_core uaer_core_properties chk_u (.MCLK_IN(MCLK_IN), .RESET_IN(RESET_IN),
    .TOKEN_IN(TOKEN_IN), .TOKEN_ACK_OUT(TOKEN_ACK_OUT), .TOKEN_STALL_OUT(TOKEN_STALL_OUT),
    .CTRL_REQ_IN(CTRL_REQ_IN), .CTRL_ACK_OUT(CTRL_ACK_OUT), .CTRL_STALL_OUT(CTRL_STALL_OUT),
    .PB_FMT_IN(PB_FMT_IN), .DAC_VALID_OUT(DAC_VALID_OUT), .SPDIF_TX_VALID_OUT(SPDIF_TX_VALID_OUT),
    .SPDIF_TX_STATUS_OUT(SPDIF_TX_STATUS_OUT), .REC_TICK_IN(REC_TICK_IN),
    .REC_VALID_OUT(REC_VALID_OUT), .LOGIC_RESET_OUT(LOGIC_RESET_OUT));

// ===== tb/uaer_host_model.sv
// usb host model: tokens, control requests and playback words
// drives just after the rising edge, reads answers one cycle later
`timescale 1ns/10ps
module uaer_host_model
    import uaer_pkg::*;
(
    input wire logic clk_in,
    input wire logic [3:0] ans_in,
    output uaer_token_t tok_out,
    output uaer_ctrl_req_t req_out,
    output logic word_valid_out,
    output logic [SAMPLE_W-1:0] word_out
);
    initial begin
        tok_out = '0;
        req_out = '0;
        word_valid_out = 1'b0;
        word_out = '0;
    end
    task automatic token(input logic din, input logic [3:0] ep, output logic [1:0] ans);
        @(posedge clk_in);
        #1 tok_out = {1'b1, din, ep};
        @(posedge clk_in);
        #1 tok_out = {1'b0, ~din, ~ep};
        ans = ans_in[3:2];
    endtask
    task automatic request(input logic [1:0] kind, output logic [1:0] ans);
        @(posedge clk_in);
        #1 req_out = {1'b1, kind};
        @(posedge clk_in);
        #1 req_out = {1'b0, ~kind};
        ans = ans_in[1:0];
    endtask
    task automatic word(input logic [SAMPLE_W-1:0] w);
        @(posedge clk_in);
        #1 word_valid_out = 1'b1;
        word_out = w;
        @(posedge clk_in);
        #1 word_valid_out = 1'b0;
        word_out = ~w;
    endtask
endmodule // uaer_host_model

// ===== tb/usb_audio_endpoint_router_test.sv
// bench for the endpoint router core
// host model on the usb side, bench drives pins, converters and s/pdif rx
`timescale 1ns/10ps
module usb_audio_endpoint_router_test;
    import uaer_pkg::*;
    localparam int unsigned HID_T = 64;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] pins = 3'h0;
    logic sof = 1'b0;
    logic tick = 1'b0;
    logic lock = 1'b0;
    uaer_fmt_t pb_fmt = '0;
    uaer_fmt_t rec_fmt = '0;
    uaer_rate_t rx_rate = RATE_48K;
    uaer_copy_mgmt_t rx_cm = 2'h1;
    uaer_stereo_t adc = 32'h1234_5678;
    uaer_stereo_t rx = 32'h9ABC_DEF0;
    uaer_token_t tok;
    uaer_ctrl_req_t req;
    uaer_stereo_t dac_s, tx_s;
    logic t_ack, t_stall, c_ack, c_stall, pb_v, dac_v, tx_v, rec_v, rec_src, hpend, lrst;
    logic [15:0] pb_w;
    logic [7:0] pb_rate;
    logic [31:0] cs, rec_d;
    logic [2:0] rec_b, hid_r;
    logic [1:0] ans;
    int miscompares = 0;
    int comparisons = 0;
    always #20 clk = ~clk;
    uaer_host_model host_u (.clk_in(clk), .ans_in({t_ack, t_stall, c_ack, c_stall}),
        .tok_out(tok), .req_out(req), .word_valid_out(pb_v), .word_out(pb_w));
    uaer_core #(.POR_CYCLES_P(20), .HID_CYCLES_P(HID_T)) dut_u (.MCLK_IN(clk), .RESET_IN(rst),
        .MUTE_REQUEST_PIN_IN(pins[0]), .VOLUME_UP_PIN_IN(pins[1]), .VOLUME_DOWN_PIN_IN(pins[2]),
        .TOKEN_IN(tok), .TOKEN_ACK_OUT(t_ack), .TOKEN_STALL_OUT(t_stall), .CTRL_REQ_IN(req),
        .CTRL_ACK_OUT(c_ack), .CTRL_STALL_OUT(c_stall), .PB_FMT_IN(pb_fmt),
        .PB_WORD_VALID_IN(pb_v), .PB_WORD_IN(pb_w), .SOF_IN(sof), .PB_RATE_OUT(pb_rate),
        .DAC_VALID_OUT(dac_v), .DAC_SAMPLE_OUT(dac_s), .SPDIF_TX_VALID_OUT(tx_v),
        .SPDIF_TX_SAMPLE_OUT(tx_s), .SPDIF_TX_STATUS_OUT(cs), .REC_FMT_IN(rec_fmt),
        .REC_TICK_IN(tick), .ADC_SAMPLE_IN(adc), .SPDIF_RX_SAMPLE_IN(rx),
        .SPDIF_RX_LOCK_IN(lock), .SPDIF_RX_RATE_IN(rx_rate), .SPDIF_RX_COPY_MGMT_IN(rx_cm),
        .REC_VALID_OUT(rec_v), .REC_DATA_OUT(rec_d), .REC_BYTES_OUT(rec_b),
        .REC_FROM_SPDIF_OUT(rec_src), .HID_REPORT_OUT(hid_r), .HID_PEND_OUT(hpend),
        .LOGIC_RESET_OUT(lrst));
    task automatic step(input int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %0t %s got %h", $time, what, got);
        end
    endtask
    task automatic end_of_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic t_reset;
        int n = 0;
        check(lrst, 1'b1, "hold");
        while (lrst !== 1'b0 && n < 100) begin
            step();
            n++;
        end
        check(n > 18 && n < 22, 1'b1, "hold length");
        $display("test reset done");
    endtask
    task automatic t_token;
        logic ok;
        for (int d = 0; d < 2; d++) begin
            for (int e = 0; e < 16; e++) begin
                ok = d ? (e inside {0, 4, 5}) : (e inside {0, 2});
                host_u.token(d[0], e[3:0], ans);
                check(ans, {ok, !ok}, "token");
            end
        end
        for (int k = 0; k < 4; k++) begin
            host_u.request(k[1:0], ans);
            check(ans, {k < 2, k > 1}, "request");
        end
        $display("test endpoints done");
    endtask
    task automatic t_hid;
        int n;
        for (int k = 0; k < 2; k++) begin
            // asymmetric levels so a swapped pin order shows
            pins = k ? 3'h6 : 3'h1;
            step(8);
            host_u.token(1'b1, 4'h5, ans);
            check(hpend, 1'b0, "hid clear");
            n = 0;
            while (hpend !== 1'b1 && n < 4 * HID_T) begin
                step();
                n++;
            end
            check(hid_r, pins, "hid levels");
        end
        check(n > HID_T - 13 && n < HID_T - 9, 1'b1, "hid period");
        $display("test hid done");
    endtask
    task automatic pulse_sof;
        sof = 1'b1;
        step();
        sof = 1'b0;
    endtask
    task automatic t_play;
        uaer_stereo_t e;
        logic [15:0] l, r;
        // every hid pin asserted while audio runs
        pins = 3'h7;
        pulse_sof();
        for (int i = 0; i < 5; i++) begin
            pb_fmt = {1'b1, i[1], i[0], i == 4 ? RATE_OTHER : RATE_48K};
            l = pb_fmt.bits8 ? 16'h77C3 : 16'hA5C3;
            r = pb_fmt.bits8 ? 16'h773C : 16'h5A3C;
            e.left = pb_fmt.bits8 ? {l[7:0], 8'h00} : l;
            e.right = pb_fmt.mono ? e.left : pb_fmt.bits8 ? {r[7:0], 8'h00} : r;
            host_u.word(l);
            if (!pb_fmt.mono) host_u.word(r);
            check({dac_v, tx_v}, {1'b1, i != 4}, "valid");
            check(dac_s, e, "dac");
            check(tx_s, e, "spdif");
        end
        step();
        pulse_sof();
        step();
        check(pb_rate, 8'h05, "rate");
        pb_fmt.active = 1'b0;
        $display("test playback done");
    endtask
    task automatic t_status;
        logic [3:0] f [4] = '{4'h2, 4'h0, 4'h3, 4'h0};
        for (int k = 0; k < 4; k++) begin
            pb_fmt.rate = uaer_rate_t'(k);
            step(2);
            check(cs, {4'h0, f[k], 24'h00_0200}, "status");
        end
        $display("test status done");
    endtask
    task automatic rec_case(input logic lk, input logic og, input logic [1:0] mb,
            input uaer_rate_t rt);
        uaer_stereo_t s;
        logic [31:0] d;
        logic [2:0] b;
        s = lk && og ? rx : adc;
        d = mb == 2'h0 ? s : mb == 2'h1 ? {16'h0000, s.left[15:8], s.right[15:8]}
            : mb == 2'h2 ? {16'h0000, s.left} : {24'h00_0000, s.left[15:8]};
        b = mb == 2'h0 ? 3'h4 : mb == 2'h3 ? 3'h1 : 3'h2;
        lock = lk;
        rx_cm.original = og;
        rx_rate = rt;
        rec_fmt = {1'b1, mb, rt};
        tick = 1'b1;
        step();
        tick = 1'b0;
        check({rec_v, rec_src, rec_b}, {1'b1, lk && og, b}, "record");
        check(rec_d, d, "record data");
        host_u.token(1'b1, 4'h4, ans);
        check(rec_v, 1'b0, "record clear");
    endtask
    task automatic t_rec;
        rec_case(1'b0, 1'b1, 2'h0, RATE_48K);
        rec_case(1'b1, 1'b1, 2'h0, RATE_48K);
        rec_case(1'b1, 1'b0, 2'h0, RATE_44K1);
        rec_case(1'b1, 1'b1, 2'h1, RATE_44K1);
        rec_case(1'b1, 1'b1, 2'h2, RATE_32K);
        // both reductions only from the adc, never against s/pdif
        rec_case(1'b0, 1'b1, 2'h3, RATE_32K);
        $display("test record done");
    endtask
    initial begin
        step(4);
        rst = 1'b0;
        t_reset();
        t_token();
        t_hid();
        t_play();
        t_status();
        t_rec();
        end_of_test();
    end
    // far longer than the whole sequence needs
    initial begin
        #400_000;
        miscompares++;
        $display("mismatch %0t watchdog", $time);
        end_of_test();
    end
endmodule // usb_audio_endpoint_router_test
